// ==== hw/pcl_loader.sv ====
/*
  program counter loader: 15-bit instruction address counter with a
  software low byte, a high-address latch and call/branch/interrupt loads,
  reached over apb.
  assumes the decoder drives one operation strobe per instruction and the
  return stack takes push data when push is high.
*/
// Chosen here: the APB slave port and the placing of the registers.
//
// Operation
// - counter is 15 bits, high 14:8, low 7:0
// - low byte is a read/write register
// - high bits not bus-writable, loaded from the latch
// - every reset clears the counter to zero
// - low-byte write copies latch into high bits
// - low write sets whole counter, no carry
// - absolute call: operand plus latch bits 6:3
// - computed call: latch high, working register low
// - relative branches add to incremented address
// - accumulator branch: address plus one plus unsigned
// - immediate branch: address plus one plus signed
// - interrupt pushes address, loads fixed vector
// - interrupt return reloads popped stack address
`timescale 1ns/100ps
`include "pcl_defs.svh"

module pcl_loader #(
  parameter int ADDR_W = `PCL_ADDR_W
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // instruction decoder side
  input  wire logic                       fetch_step,
  input  wire pcl_pkg::pcl_op_t           core_op,
  input  wire logic                       core_op_valid,
  input  wire logic [`PCL_LOW_W-1:0]      core_low_data,
  input  wire logic [`PCL_LOW_W-1:0]      wreg,
  input  wire logic [`PCL_CALL_OP_W-1:0]  operand,
  // return stack side
  input  wire logic [ADDR_W-1:0]          stack_top,
  output logic                            stack_push,
  output logic                            stack_pop,
  output logic      [ADDR_W-1:0]          stack_push_data,
  // counter to the fetch unit
  output logic      [ADDR_W-1:0]          instr_addr
);
  import pcl_pkg::*;

  // state
  logic [`PCL_ADDR_W-1:0] counter_reg;     // instruction address
  logic [`PCL_HIGH_W-1:0] latch_reg;       // high-address latch
  logic [ADDR_W-1:0]      push_data_reg;   // address handed to the stack
  logic                   push_reg;        // one-cycle push strobe
  logic                   pop_reg;         // one-cycle pop strobe
  logic [31:0]            rdata_reg;       // registered read data

  // bus decode
  logic       bus_setup;                   // setup phase seen
  logic       bus_write;                   // write taken this edge
  logic       bus_read;                    // read taken this edge
  logic       addr_ok;                     // mapped offset
  logic       sw_low_write;                // software write to low byte
  logic       sw_cmd_write;                // software command strobe

  // selected operation and its target
  pcl_op_t                op_sel;
  logic                   op_live;
  logic [`PCL_ADDR_W-1:0] target;

  // decode of a mapped offset, used only for the error response
  function automatic logic offset_mapped(input logic [11:0] a);
    offset_mapped = (a == `PCL_OFF_LOW) || (a == `PCL_OFF_LATCH)
                 || (a == `PCL_OFF_COUNTER) || (a == `PCL_OFF_CMD);
  endfunction

  // apb: single-cycle access, every access ends in its first access cycle
  assign bus_setup    = psel & ~penable;
  assign bus_write    = psel & penable & pwrite;
  assign bus_read     = psel & penable & ~pwrite;
  assign addr_ok      = offset_mapped(paddr);
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~addr_ok;
  assign prdata       = rdata_reg;

  // software reaches the low byte as an ordinary data register
  assign sw_low_write = bus_write & (paddr == `PCL_OFF_LOW);
  assign sw_cmd_write = bus_write & (paddr == `PCL_OFF_CMD);

  // operation priority: any core op first, interrupt entry/return
  // included, then a software low write, then software command,
  // then the plain fetch step
  always_comb begin
    op_sel  = PCL_OP_STEP;
    op_live = 1'b0;
    if (core_op_valid) begin
      op_sel  = core_op;
      op_live = 1'b1;
    end else if (sw_low_write) begin
      op_sel  = PCL_OP_LOW_WRITE;
      op_live = 1'b1;
    end else if (sw_cmd_write) begin
      op_sel  = pcl_op_t'(pwdata[`PCL_CMD_W-1:0]);
      op_live = 1'b1;
    end else if (fetch_step) begin
      op_sel  = PCL_OP_STEP;
      op_live = 1'b1;
    end
  end

  // low data: a software write carries the bus byte, else the core result
  logic [`PCL_LOW_W-1:0] low_data;
  assign low_data = (!core_op_valid && sw_low_write) ? pwdata[`PCL_LOW_MSB:0]
                                                     : core_low_data;

  // target former
  pcl_target u_target (
    .op        (op_sel),
    .counter   (counter_reg),
    .latch     (latch_reg),
    .wreg      (wreg),
    .operand   (operand),
    .low_data  (low_data),
    .stack_top (stack_top[`PCL_ADDR_W-1:0]),
    .target    (target)
  );

  // counter: cleared by reset, else loaded when an operation is live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_reg <= `PCL_RST_COUNTER;
    end else if (op_live) begin
      counter_reg <= target;
    end
  end

  // high-address latch: written only by software, never read back into
  // the counter except through a low write or a call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= `PCL_RST_LATCH;
    end else if (bus_write && paddr == `PCL_OFF_LATCH) begin
      latch_reg <= pwdata[`PCL_HIGH_W-1:0];
    end
  end

  // return stack strobes: push on interrupt entry, pop on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_reg      <= 1'b0;
      pop_reg       <= 1'b0;
      push_data_reg <= '0;
    end else begin
      push_reg <= op_live && (op_sel == PCL_OP_INT_ENTRY);
      pop_reg  <= op_live && (op_sel == PCL_OP_INT_RETURN);
      if (op_live && op_sel == PCL_OP_INT_ENTRY) begin
        push_data_reg <= ADDR_W'(counter_reg);
      end
    end
  end

  assign stack_push      = push_reg;
  assign stack_pop       = pop_reg;
  assign stack_push_data = push_data_reg;
  assign instr_addr      = ADDR_W'(counter_reg);

  // read data: low byte readable, high bits hidden, counter shown for debug
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_setup && !pwrite) begin
      case (paddr)
        `PCL_OFF_LOW:     rdata_reg <= {24'h00_0000,
                                        counter_reg[`PCL_LOW_MSB:0]};
        `PCL_OFF_LATCH:   rdata_reg <= {25'h000_0000, latch_reg};
        `PCL_OFF_COUNTER: rdata_reg <= {17'h0_0000, counter_reg};
        default:          rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== hw/pcl_defs.svh ====
/*
  constants for the program counter loader: widths, register offsets,
  field positions, reset values and the interrupt vector.
  assumes nothing beyond being included by bare name.
*/
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

// counter layout
`define PCL_ADDR_W        15
`define PCL_LOW_W         8
`define PCL_HIGH_W        7
`define PCL_LOW_MSB       7
`define PCL_HIGH_MSB      14
`define PCL_HIGH_LSB      8
// absolute call operand covers high bits 2:0 and low byte
`define PCL_CALL_OP_W     11
`define PCL_CALL_LATCH_LSB 3

// apb register byte offsets
`define PCL_OFF_LOW       12'h000
`define PCL_OFF_LATCH     12'h004
`define PCL_OFF_COUNTER   12'h008
`define PCL_OFF_CMD       12'h00C

// reset values
`define PCL_RST_COUNTER   15'h0000
`define PCL_RST_LATCH     7'h00

// fixed interrupt vector
`define PCL_INT_VECTOR    15'h0004

// command register: low bits select an operation, write strobes it
`define PCL_CMD_W         3

`endif

// ==== hw/pcl_pkg.sv ====
/*
  types for the program counter loader.
  assumes pcl_defs.svh is on the include path.
*/
`include "pcl_defs.svh"

package pcl_pkg;

  // counter load operation chosen for one cycle
  typedef enum logic [`PCL_CMD_W-1:0] {
    PCL_OP_STEP,
    PCL_OP_LOW_WRITE,
    PCL_OP_CALL_ABS,
    PCL_OP_CALL_COMPUTED,
    PCL_OP_JUMP_ACC,
    PCL_OP_JUMP_IMM,
    PCL_OP_INT_ENTRY,
    PCL_OP_INT_RETURN
  } pcl_op_t;

  // bus phase state of the apb slave, not used by pcl_loader
  typedef enum logic [1:0] {
    PCL_BUS_IDLE,
    PCL_BUS_ACCESS
  } pcl_bus_t;

endpackage

// ==== hw/pcl_target.sv ====
/*
  combinational target former: from the current counter, latch, working
  register and operand it gives the next counter value for one operation.
  assumes the caller registers the result.
*/
`timescale 1ns/100ps
`include "pcl_defs.svh"

module pcl_target (
  input  wire pcl_pkg::pcl_op_t                 op,
  input  wire logic [`PCL_ADDR_W-1:0]           counter,
  input  wire logic [`PCL_HIGH_W-1:0]           latch,
  input  wire logic [`PCL_LOW_W-1:0]            wreg,
  input  wire logic [`PCL_CALL_OP_W-1:0]        operand,
  input  wire logic [`PCL_LOW_W-1:0]            low_data,
  input  wire logic [`PCL_ADDR_W-1:0]           stack_top,
  output logic      [`PCL_ADDR_W-1:0]           target
);
  import pcl_pkg::*;

  // already-incremented base, wraps in 15 bits
  logic [`PCL_ADDR_W-1:0] base_inc;
  // signed immediate offset extended across the full counter
  logic [`PCL_ADDR_W-1:0] imm_ext;

  assign base_inc = counter + `PCL_ADDR_W'(1);
  assign imm_ext  = {{(`PCL_ADDR_W-`PCL_LOW_W){operand[`PCL_LOW_MSB]}},
                     operand[`PCL_LOW_MSB:0]};

  // choose the target per operation
  always_comb begin
    case (op)
      PCL_OP_STEP:          target = base_inc;
      PCL_OP_LOW_WRITE:     target = {latch, low_data};
      PCL_OP_CALL_ABS:      target = {latch[`PCL_HIGH_W-1:`PCL_CALL_LATCH_LSB],
                                      operand};
      PCL_OP_CALL_COMPUTED: target = {latch, wreg};
      PCL_OP_JUMP_ACC:      target = base_inc
                                     + {{(`PCL_ADDR_W-`PCL_LOW_W){1'b0}}, wreg};
      PCL_OP_JUMP_IMM:      target = base_inc + imm_ext;
      PCL_OP_INT_ENTRY:     target = `PCL_INT_VECTOR;
      PCL_OP_INT_RETURN:    target = stack_top;
      default:              target = counter;
    endcase
  end

endmodule

// ==== testbench/pcl_loader_chk.sv ====
/* checker for pcl_loader: counter loads, stack strobes, low-byte writes.
   assumes it is bound to the pcl_loader ports and sees only those. */
`timescale 1ns/100ps
`include "pcl_defs.svh"
module pcl_loader_chk #(parameter int ADDR_W = 15) (
  input wire logic                      pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic                      fetch_step, core_op_valid,
  input wire pcl_pkg::pcl_op_t          core_op,
  input wire logic [`PCL_LOW_W-1:0]     core_low_data, wreg,
  input wire logic [`PCL_CALL_OP_W-1:0] operand,
  input wire logic [ADDR_W-1:0]         stack_top, stack_push_data, instr_addr,
  input wire logic                      stack_push, stack_pop
);
  import pcl_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire              wr   = psel && penable && pwrite; // apb write taken
  wire [ADDR_W-1:0] inc  = instr_addr + 1'b1;          // incremented base
  wire [ADDR_W-1:0] simm = {{7{operand[7]}}, operand[7:0]}; // signed offset
  wire [ADDR_W-1:0] uacc = {7'h00, wreg};              // unsigned offset
  wire [7:0]        wlow = pwdata[7:0];                // written low byte
  logic [6:0]       lat_q;                             // shadow of the latch
  // follow software writes to the high-address latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lat_q <= 7'h00;
    else if (wr && paddr == `PCL_OFF_LATCH) lat_q <= pwdata[6:0];
  end
  sequence s_push; ##[0:1] stack_push; endsequence
  sequence s_pop; ##[0:1] stack_pop; endsequence
  // one-hot of the live core operation, a plain signal so properties see sampled values
  logic [7:0]       op_hit;
  assign op_hit = core_op_valid ? (8'h01 << core_op) : 8'h00;
  property p_reset; $rose(presetn) |-> instr_addr == '0; endproperty
  property p_step; fetch_step && !core_op_valid && !wr |=> instr_addr == $past(inc); endproperty
  property p_low; op_hit[PCL_OP_LOW_WRITE]
    |=> instr_addr == {$past(lat_q), $past(core_low_data)}; endproperty
  property p_lowsw; wr && paddr == `PCL_OFF_LOW && !core_op_valid
    |=> instr_addr == {$past(lat_q), $past(wlow)}; endproperty
  property p_abs; op_hit[PCL_OP_CALL_ABS]
    |=> instr_addr == {$past(lat_q[6:3]), $past(operand)}; endproperty
  property p_comp; op_hit[PCL_OP_CALL_COMPUTED]
    |=> instr_addr == {$past(lat_q), $past(wreg)}; endproperty
  property p_acc; op_hit[PCL_OP_JUMP_ACC]
    |=> instr_addr == $past(inc) + $past(uacc); endproperty
  property p_imm; op_hit[PCL_OP_JUMP_IMM]
    |=> instr_addr == $past(inc) + $past(simm); endproperty
  property p_int; op_hit[PCL_OP_INT_ENTRY] |-> ##1 (instr_addr == `PCL_INT_VECTOR
    && stack_push_data == $past(instr_addr)) ##0 s_push; endproperty
  property p_ret; op_hit[PCL_OP_INT_RETURN]
    |-> ##1 instr_addr == $past(stack_top) ##0 s_pop; endproperty
  a_reset: assert property (p_reset) else $error("counter not zero after reset");
  a_step: assert property (p_step) else $error("step did not add one");
  a_low: assert property (p_low) else $error("core low write wrong");
  a_lowsw: assert property (p_lowsw) else $error("bus low write wrong");
  a_abs: assert property (p_abs) else $error("absolute call wrong");
  a_comp: assert property (p_comp) else $error("computed call wrong");
  a_acc: assert property (p_acc) else $error("accumulator branch wrong");
  a_imm: assert property (p_imm) else $error("immediate branch wrong");
  a_int: assert property (p_int) else $error("interrupt entry wrong");
  a_ret: assert property (p_ret) else $error("interrupt return wrong");
endmodule
bind pcl_loader pcl_loader_chk #(.ADDR_W(ADDR_W)) i_pcl_loader_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .fetch_step(fetch_step), .core_op_valid(core_op_valid),
  .core_op(core_op), .core_low_data(core_low_data), .wreg(wreg), .operand(operand),
  .stack_top(stack_top), .stack_push_data(stack_push_data), .instr_addr(instr_addr),
  .stack_push(stack_push), .stack_pop(stack_pop));

// ==== testbench/pcl_stack_model.sv ====
/* return stack model: stores pushed addresses, shows the top, pops on strobe.
   assumes at most one strobe per cycle from the loader. */
`timescale 1ns/100ps
module pcl_stack_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic [14:0] stack_push_data,
  output logic      [14:0] stack_top
);
  logic [14:0] mem [0:7]; // stored return addresses
  logic [2:0]  sp_reg;    // entries held
  // an empty stack shows no stale address
  assign stack_top = (sp_reg != 3'h0) ? mem[sp_reg - 3'h1] : ~stack_push_data;
  // push and pop bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sp_reg <= 3'h0;
    else if (stack_push) begin
      mem[sp_reg] <= stack_push_data;
      sp_reg <= sp_reg + 3'h1;
    end else if (stack_pop && sp_reg != 3'h0) sp_reg <= sp_reg - 3'h1;
  end
endmodule

// ==== testbench/program_counter_loader_tb.sv ====
/* self-checking bench for pcl_loader: apb and core-op tasks, stack model.
   assumes zero-wait apb answers and the offsets of pcl_defs.svh. */
`timescale 1ns/100ps
`include "pcl_defs.svh"
module program_counter_loader_tb;
  import pcl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fetch_step = 0;
  logic core_op_valid = 0, pready, pslverr, stack_push, stack_pop, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  pcl_op_t core_op = PCL_OP_STEP;
  logic [7:0] core_low_data = 8'h00, wreg = 8'h00;
  logic [10:0] operand = 11'h000;
  logic [14:0] stack_top, stack_push_data, instr_addr, pc, p;
  logic [6:0] lat;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #25 pclk = ~pclk;
  pcl_loader i_pcl_loader (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_step(fetch_step), .core_op(core_op),
    .core_op_valid(core_op_valid), .core_low_data(core_low_data), .wreg(wreg),
    .operand(operand), .stack_top(stack_top), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_push_data(stack_push_data), .instr_addr(instr_addr));
  pcl_stack_model i_pcl_stack_model (.pclk(pclk), .presetn(presetn), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_push_data(stack_push_data), .stack_top(stack_top));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    @(posedge pclk); while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    // let the load made at the access edge settle before anyone looks
    @(negedge pclk);
  endtask
  // one core operation, then the counter is compared
  task op(input pcl_op_t o, input logic [14:0] e);
    @(posedge pclk); core_op <= o; core_op_valid <= 1;
    @(posedge pclk); core_op_valid <= 0;
    @(negedge pclk); chk(instr_addr, e); pc = e;
  endtask
  task setpc(input logic [6:0] l, input logic [7:0] b);
    lat = l;
    apb(1, `PCL_OFF_LATCH, l); apb(1, `PCL_OFF_LOW, b);
    @(negedge pclk); pc = {l, b};
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin n_errors++; final_report; end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk); chk(instr_addr, 0);
    setpc(7'h55, 8'hFE); chk(instr_addr, pc);
    apb(0, `PCL_OFF_LOW, 0); chk(rd, 32'hFE);
    apb(0, `PCL_OFF_LATCH, 0); chk(rd, 32'h55);
    apb(1, `PCL_OFF_COUNTER, 0); chk(instr_addr, pc);
    apb(0, `PCL_OFF_COUNTER, 0); chk(rd, pc);
    $display("register test done");
    op(PCL_OP_STEP, pc + 1'b1);
    @(posedge pclk) fetch_step <= 1;
    @(posedge pclk) fetch_step <= 0;
    @(negedge pclk) chk(instr_addr, pc + 1'b1);
    setpc(7'h7F, 8'hFF); apb(1, `PCL_OFF_CMD, 32'h0); chk(instr_addr, 0);
    $display("step test done");
    setpc(7'h2A, 8'h10);
    @(posedge pclk) core_low_data <= 8'hFF;
    op(PCL_OP_LOW_WRITE, {lat, 8'hFF});
    @(posedge pclk) operand <= 11'h6A5;
    op(PCL_OP_CALL_ABS, {lat[6:3], 11'h6A5});
    @(posedge pclk) wreg <= 8'hC3;
    op(PCL_OP_CALL_COMPUTED, {lat, 8'hC3});
    @(posedge pclk) wreg <= 8'hF0;
    op(PCL_OP_JUMP_ACC, pc + 15'h1 + 15'h00F0);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk) operand <= i ? 11'h07F : 11'h080;
      op(PCL_OP_JUMP_IMM, pc + 15'h1 + (i ? 15'h007F : 15'h7F80));
    end
    apb(1, `PCL_OFF_CMD, 32'(PCL_OP_JUMP_ACC)); chk(instr_addr, pc + 15'h00F1);
    pc = pc + 15'h00F1;
    $display("load test done");
    p = pc; op(PCL_OP_INT_ENTRY, `PCL_INT_VECTOR); chk(stack_push_data, p);
    op(PCL_OP_STEP, pc + 1'b1); op(PCL_OP_INT_RETURN, p);
    $display("interrupt test done");
    apb(0, 12'h010, 0); chk(rd, 0); chk(err, 1);
    @(posedge pclk) presetn <= 0;
    @(negedge pclk) chk(instr_addr, 0);
    @(posedge pclk) presetn <= 1;
    @(negedge pclk) chk(instr_addr, 0);
    op(PCL_OP_STEP, 15'h0001);
    $display("error and reset test done");
    final_report;
  end
endmodule
